// ---- core/rbm_defs.svh ----
// constants for the reset and boot-mode control block
// assumes inclusion by the package and the bench
`ifndef RBM_DEFS_SVH
`define RBM_DEFS_SVH
`define RBM_BOOT_WORDS       6'h20
`define RBM_START_ADDR       14'h0000
`define RBM_EXT_START_ADDR   14'h0000
`define RBM_OVL_LO           14'h2000
`define RBM_OVL_HI           14'h3FFF
`define RBM_OVL_RESERVED     2'h0
`define RBM_OVL_ONE          2'h1
`define RBM_OVL_TWO          2'h2
`define RBM_PM_WIDTH         24
`define RBM_HOST_BUS_WIDTH   16
`define RBM_WAIT_W           3
`define RBM_MODE_STATUS_REG_RESET      7'h00
`define RBM_MODE_STATUS_REG_W          7
`endif

// ---- core/rbm_pkg.sv ----
// types for the reset and boot-mode control block
// assumes rbm_defs.svh on the include path
package rbm_pkg;
`include "rbm_defs.svh"
   typedef struct packed
   {
      logic mode_d;
      logic mode_c;
      logic mode_b;
      logic mode_a;
   } rbm_straps_t;

   typedef enum logic [1:0]
   {
      RBM_BOOT_BYTE = 2'h0,
      RBM_BOOT_NONE = 2'h1,
      RBM_BOOT_HOST = 2'h2,
      RBM_BOOT_BAD  = 2'h3
   } rbm_boot_t;

   typedef enum logic [1:0]
   {
      RBM_ST_RESET = 2'h0,
      RBM_ST_BOOT  = 2'h1,
      RBM_ST_RUN   = 2'h2
   } rbm_state_t;

   typedef struct packed
   {
      logic      host_mode;
      logic      ack_open_drain;
      rbm_boot_t boot;
   } rbm_cfg_t;
endpackage : rbm_pkg

// ---- core/rbm_strap_latch.sv ----
// strap capture: decodes mode pins and holds them from reset release
// assumes straps are stable while resetn is low
`timescale 1ns/1ps
module rbm_strap_latch
   import rbm_pkg::*;
(
   input  wire logic        mclk,
   input  wire logic        resetn,
   input  wire rbm_straps_t straps,
   output      rbm_cfg_t    cfg
);
   logic     held;
   rbm_cfg_t decoded;
   logic     next_held;
   rbm_cfg_t next_cfg;

   always_comb
   begin
      decoded.host_mode      = straps.mode_c;
      decoded.ack_open_drain = straps.mode_d;
      unique case ({straps.mode_c, straps.mode_b, straps.mode_a})
         3'h0:    decoded.boot = RBM_BOOT_BYTE;
         3'h2:    decoded.boot = RBM_BOOT_NONE;
         3'h4:    decoded.boot = RBM_BOOT_BYTE;
         3'h5:    decoded.boot = RBM_BOOT_HOST;
         default: decoded.boot = RBM_BOOT_BAD;
      endcase
   end

   // follow the straps on every edge while reset holds, so the level seen at release is kept;
   // released strap drivers may move at once, so nothing is taken after release
   always_comb
   begin
      next_held = 1'b1;
      next_cfg  = resetn ? cfg : decoded;
   end

   always_ff @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
         held <= 1'b0;
      else
         held <= next_held;
   end

   always_ff @(posedge mclk)
   begin
      cfg <= next_cfg;
   end

   property p_cfg_stable;
      @(posedge mclk) disable iff (!resetn)
      held |=> $stable(cfg);
   endproperty
   a_cfg_stable: assert property (p_cfg_stable) else $error("strap config changed after capture"); // RULE21
endmodule : rbm_strap_latch

// ---- core/rbm_wait_gen.sv ----
// external data access wait-state counter
// assumes one access request pulse at a time
`timescale 1ns/1ps
module rbm_wait_gen
#(
   parameter int WAIT_W = 3
)
(
   input  wire logic              mclk,
   input  wire logic              resetn,
   input  wire logic              start,
   input  wire logic              external,
   input  wire logic [WAIT_W-1:0] wait_states,
   input  wire logic              wait_mode,
   output      logic              done
);
   logic [WAIT_W:0] count;
   logic            busy;
   logic [WAIT_W:0] next_count;
   logic            next_busy;
   logic            next_done;

   initial
   begin
      if (WAIT_W < 1 || WAIT_W > 4)
         $error("WAIT_W out of range");
   end

   // wait mode doubles the field and adds one, up to 2n+1 states
   always_comb
   begin
      next_count = count;
      next_busy  = busy;
      next_done  = 1'b0;
      if (start && !busy)
      begin
         if (!external || wait_states == '0)
            next_done = 1'b1;
         else
         begin
            next_busy  = 1'b1;
            next_count = wait_mode ? {wait_states, 1'b1} : {1'b0, wait_states};
         end
      end
      else if (busy)
      begin
         if (count == {{WAIT_W{1'b0}}, 1'b1})
         begin
            next_busy = 1'b0;
            next_done = 1'b1;
         end
         next_count = count - 1'b1;
      end
   end

   always_ff @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
      begin
         count <= '0;
         busy  <= 1'b0;
         done  <= 1'b0;
      end
      else
      begin
         count <= next_count;
         busy  <= next_busy;
         done  <= next_done;
      end
   end
endmodule : rbm_wait_gen

// ---- core/rbm_reset_boot.sv ----
// reset and boot-mode control: reset state, boot sequencing, memory-map mode
// assumes synchronous strap, dma and bus inputs; straps driven during reset
// How it works
// [RULE1] low reset input fully resets the processor
// [RULE2] board holds reset 2000 input clocks initially; the bench holds it 23 clocks
// [RULE3] later resets need no clock stabilization wait
// [RULE4] reset empties stacks, masks interrupts, clears status
// [RULE5] boot runs only without bus request
// [RULE6] first fetch from program address zero
// [RULE7] mode C strap taken at reset, shared flag
// [RULE8] C,B,A=000: full memory, byte boot 32
// [RULE9] C,B,A=010: full memory, no boot, external 0
// [RULE10] C,B,A=100: host mode, byte boot 32
// [RULE11] C,B,A=101: host mode, wait pm 0 write
// [RULE12] mode D picks driven or open-drain acknowledge
// [RULE13] open-drain acknowledge needs external pull-down
// [RULE14] mode C driver drives only during reset
// [RULE15] flag two direction advice for power-down
// [RULE16] full memory: 24-bit program, two overlays
// [RULE17] host mode: no external execution, A0 only
// [RULE18] overlay select 1 gives A13 low, 2 high
// [RULE19] full memory: 16-bit data, two overlays
// [RULE20] internal data single cycle, external wait states
// [RULE21] straps latched at release, held until reset
// [RULE22] fetch stalled until boot completion condition
`timescale 1ns/1ps
module rbm_reset_boot
   import rbm_pkg::*;
#(
   parameter int BOOT_WORDS = 32,
   parameter int WAIT_W     = `RBM_WAIT_W
)
(
   input  wire logic              mclk,
   input  wire logic              resetn,
   input  wire rbm_straps_t       straps,
   input  wire logic              shared_flag_two_in,
   input  wire logic              flag_two_dir_out,
   input  wire logic              flag_two_value,
   input  wire logic              bus_request,
   input  wire logic              byte_mem_dma_word_done,
   input  wire logic              host_port_dma_write,
   input  wire logic [13:0]       host_port_dma_addr,
   input  wire logic              host_port_dma_to_pm,
   input  wire logic              host_ack_req,
   input  wire logic [1:0]        prog_overlay_select,
   input  wire logic [13:0]       prog_addr,
   input  wire logic              prog_ext_exec_req,
   input  wire logic              data_access,
   input  wire logic              data_external,
   input  wire logic [WAIT_W-1:0] data_wait_states,
   input  wire logic              wait_state_mode,
   output      logic              core_reset,
   output      logic              stacks_empty,
   output      logic              irq_mask_all,
   output      logic [6:0]        mode_status_reg,
   output      logic              fetch_enable,
   output      logic [13:0]       fetch_addr,
   output      logic              fetch_external,
   output      logic              byte_mem_dma_boot_start,
   output      logic              host_mode,
   output      logic              shared_flag_two_out,
   output      logic              shared_flag_two_oe,
   output      logic              flag_two_read,
   output      logic              host_access_ack_n_out,
   output      logic              host_access_ack_n_oe,
   output      logic              ovl_addr_a13,
   output      logic [12:0]       ovl_addr_low,
   output      logic              ovl_valid,
   output      logic              ext_exec_allowed,
   output      logic [4:0]        prog_width,
   output      logic              data_ready
);
   rbm_cfg_t   cfg;
   rbm_state_t state;
   rbm_state_t next_state;
   logic [5:0] boot_count;
   logic [5:0] next_boot_count;
   logic       first;
   logic       next_first;
   logic       boot_done_cond;

   initial
   begin
      if (BOOT_WORDS < 1 || BOOT_WORDS > 63)
         $error("BOOT_WORDS out of range");
   end

   rbm_strap_latch u_straps
   (
      .mclk   (mclk),
      .resetn (resetn),
      .straps (straps),
      .cfg    (cfg)
   ); // RULE7 RULE21

   rbm_wait_gen #(.WAIT_W(WAIT_W)) u_wait
   (
      .mclk        (mclk),
      .resetn      (resetn),
      .start       (data_access),
      .external    (data_external),
      .wait_states (data_wait_states),
      .wait_mode   (wait_state_mode),
      .done        (data_ready)
   ); // RULE20

   // boot completion: byte boot after word count, host boot on pm address 0 write
   always_comb
   begin
      unique case (cfg.boot)
         RBM_BOOT_BYTE: boot_done_cond = (boot_count == 6'(BOOT_WORDS)); // RULE8 RULE10
         RBM_BOOT_HOST: boot_done_cond = host_port_dma_write && host_port_dma_to_pm
                                         && host_port_dma_addr == `RBM_START_ADDR; // RULE11
         default:       boot_done_cond = 1'b1;
      endcase
   end

   always_comb
   begin
      next_state      = state;
      next_boot_count = boot_count;
      next_first      = 1'b0;
      unique case (state)
         RBM_ST_RESET:
         begin
            // no clock stabilization count: leave reset on the first edge
            if (bus_request || cfg.boot == RBM_BOOT_NONE || cfg.boot == RBM_BOOT_BAD) // RULE3 RULE5
            begin
               next_state = RBM_ST_RUN;
               next_first = 1'b1;
            end
            else
               next_state = RBM_ST_BOOT;
         end
         RBM_ST_BOOT:
         begin
            if (byte_mem_dma_word_done && boot_count != 6'(BOOT_WORDS))
               next_boot_count = boot_count + 6'h01;
            if (boot_done_cond) // RULE22
            begin
               next_state = RBM_ST_RUN;
               next_first = 1'b1;
            end
         end
         RBM_ST_RUN: ;
         default: next_state = RBM_ST_RESET;
      endcase
   end

   always_ff @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
      begin
         state      <= RBM_ST_RESET; // RULE1
         boot_count <= '0;
         first      <= 1'b0;
      end
      else
      begin
         state      <= next_state;
         boot_count <= next_boot_count;
         first      <= next_first;
      end
   end

   // master reset effects, held until the boot sequence ends
   always_ff @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
      begin
         mode_status_reg <= `RBM_MODE_STATUS_REG_RESET; // RULE4
         fetch_addr      <= `RBM_START_ADDR;
         fetch_external  <= 1'b0;
      end
      else
      begin
         mode_status_reg <= mode_status_reg;
         if (next_first)
         begin
            fetch_addr     <= (cfg.boot == RBM_BOOT_NONE) ? `RBM_EXT_START_ADDR : `RBM_START_ADDR; // RULE6 RULE9
            fetch_external <= (cfg.boot == RBM_BOOT_NONE) && !cfg.host_mode; // RULE9
         end
      end
   end

   assign core_reset              = (state == RBM_ST_RESET); // RULE1
   assign stacks_empty            = (state != RBM_ST_RUN); // RULE4
   assign irq_mask_all            = (state != RBM_ST_RUN); // RULE4
   assign fetch_enable            = (state == RBM_ST_RUN); // RULE22
   assign byte_mem_dma_boot_start = (state == RBM_ST_BOOT) && (cfg.boot == RBM_BOOT_BYTE); // RULE8 RULE10
   assign host_mode               = cfg.host_mode;

   // shared flag two: never driven while reset holds the strap
   assign shared_flag_two_oe  = resetn && !core_reset && flag_two_dir_out; // RULE7 RULE14
   assign shared_flag_two_out = flag_two_value;
   assign flag_two_read       = shared_flag_two_in;

   // acknowledge: driven both ways, or open drain driving only high, the pull-down gives low
   always_comb
   begin
      host_access_ack_n_out = !host_ack_req;
      if (!cfg.host_mode)
         host_access_ack_n_oe = 1'b0;
      else if (cfg.ack_open_drain)
      begin
         host_access_ack_n_out = 1'b1;
         host_access_ack_n_oe  = !host_ack_req; // RULE12 RULE13
      end
      else
         host_access_ack_n_oe = 1'b1; // RULE12
   end

   // overlay address generation
   always_comb
   begin
      ovl_valid    = ((prog_overlay_select == `RBM_OVL_ONE) || (prog_overlay_select == `RBM_OVL_TWO))
                     && prog_addr >= `RBM_OVL_LO && prog_addr <= `RBM_OVL_HI; // RULE18
      ovl_addr_a13 = (prog_overlay_select == `RBM_OVL_TWO); // RULE18
      ovl_addr_low = prog_addr[12:0]; // RULE18
      if (cfg.host_mode)
      begin
         ovl_addr_a13 = 1'b0; // RULE17
         ovl_addr_low = {12'h000, prog_addr[0]}; // RULE17
      end
   end

   assign ext_exec_allowed = prog_ext_exec_req && !cfg.host_mode; // RULE17
   assign prog_width       = cfg.host_mode ? 5'(`RBM_HOST_BUS_WIDTH) : 5'(`RBM_PM_WIDTH); // RULE16 RULE19

   property p_run_after_reset;
      @(posedge mclk) disable iff (!resetn)
      $rose(fetch_enable) |-> $past(state) != RBM_ST_RUN;
   endproperty
   a_run_after_reset: assert property (p_run_after_reset) else $error("fetch began oddly"); // RULE22

   property p_reset_masks;
      @(posedge mclk) disable iff (!resetn)
      core_reset |-> irq_mask_all && stacks_empty && mode_status_reg == 7'h00;
   endproperty
   a_reset_masks: assert property (p_reset_masks) else $error("reset state incomplete"); // RULE4

   property p_no_boot_busreq;
      @(posedge mclk) disable iff (!resetn)
      core_reset && bus_request |=> state == RBM_ST_RUN;
   endproperty
   a_no_boot_busreq: assert property (p_no_boot_busreq) else $error("boot ran with bus request"); // RULE5

   property p_byte_boot_count;
      @(posedge mclk) disable iff (!resetn)
      state == RBM_ST_BOOT && cfg.boot == RBM_BOOT_BYTE && boot_count != 6'(BOOT_WORDS) |=> !fetch_enable;
   endproperty
   a_byte_boot_count: assert property (p_byte_boot_count) else $error("fetch before boot words"); // RULE8

   property p_host_boot;
      @(posedge mclk) disable iff (!resetn)
      state == RBM_ST_BOOT && cfg.boot == RBM_BOOT_HOST && !boot_done_cond |=> !fetch_enable;
   endproperty
   a_host_boot: assert property (p_host_boot) else $error("fetch before pm 0 written"); // RULE11

   property p_first_addr;
      @(posedge mclk) disable iff (!resetn)
      $rose(fetch_enable) && cfg.boot != RBM_BOOT_NONE |-> fetch_addr == 14'h0000 && !fetch_external;
   endproperty
   a_first_addr: assert property (p_first_addr) else $error("first fetch not at 0"); // RULE6

   property p_no_boot_ext;
      @(posedge mclk) disable iff (!resetn)
      $rose(fetch_enable) && cfg.boot == RBM_BOOT_NONE |-> fetch_external;
   endproperty
   a_no_boot_ext: assert property (p_no_boot_ext) else $error("no-boot start not external"); // RULE9

   property p_ack_od;
      @(posedge mclk) disable iff (!resetn)
      cfg.host_mode && cfg.ack_open_drain && host_access_ack_n_oe |-> host_access_ack_n_out;
   endproperty
   a_ack_od: assert property (p_ack_od) else $error("open drain drove low"); // RULE12

   property p_host_no_exec;
      @(posedge mclk) disable iff (!resetn)
      cfg.host_mode |-> !ext_exec_allowed && ovl_addr_low[12:1] == 12'h000;
   endproperty
   a_host_no_exec: assert property (p_host_no_exec) else $error("host mode external exec"); // RULE17

   property p_ovl_a13;
      @(posedge mclk) disable iff (!resetn)
      !cfg.host_mode && prog_overlay_select == 2'h1 |-> !ovl_addr_a13;
   endproperty
   a_ovl_a13: assert property (p_ovl_a13) else $error("overlay 1 A13 high"); // RULE18

   property p_flag_quiet_reset;
      @(posedge mclk) disable iff (!resetn)
      core_reset |-> !shared_flag_two_oe;
   endproperty
   a_flag_quiet_reset: assert property (p_flag_quiet_reset) else $error("flag driven in reset"); // RULE7

   property p_internal_one_cycle;
      @(posedge mclk) disable iff (!resetn)
      data_access && !data_external |=> data_ready;
   endproperty
   a_internal_one_cycle: assert property (p_internal_one_cycle) else $error("internal access slow"); // RULE20

   c_byte_boot: cover property (@(posedge mclk) disable iff (!resetn)
      state == RBM_ST_BOOT && cfg.boot == RBM_BOOT_BYTE ##1 fetch_enable);
   c_host_boot: cover property (@(posedge mclk) disable iff (!resetn)
      state == RBM_ST_BOOT && cfg.boot == RBM_BOOT_HOST ##1 fetch_enable);
   c_no_boot: cover property (@(posedge mclk) disable iff (!resetn)
      $rose(fetch_enable) && fetch_external);
   c_bus_request_skip: cover property (@(posedge mclk) disable iff (!resetn)
      core_reset && bus_request ##1 fetch_enable);
endmodule : rbm_reset_boot

// ---- verif/rbm_board_model.sv ----
// board-side model: reset-time strap drivers, byte boot memory, host dma port, pulls
// assumes the bench changes resetn and the limits at the falling edge
`timescale 1ns/1ps
module rbm_board_model
   import rbm_pkg::*;
(
   input  wire logic        mclk,
   input  wire logic        resetn,
   input  wire rbm_straps_t strap_val,
   input  wire logic [5:0]  word_limit,
   input  wire logic        slow,
   input  wire logic [1:0]  host_steps,
   input  wire logic        boot_start,
   input  wire logic        flag_out,
   input  wire logic        flag_oe,
   input  wire logic        ack_out,
   input  wire logic        ack_oe,
   output      rbm_straps_t straps,
   output      logic        word_done,
   output      logic        dma_write,
   output      logic [13:0] dma_addr,
   output      logic        dma_to_pm,
   output      logic        flag_pin,
   output      logic        ack_pin
);
   logic [5:0] sent;
   logic [1:0] step;
   logic       gap;
   // released strap lines no longer hold the strapped level
   assign straps   = resetn ? ~strap_val : strap_val;
   // passive pull-up on the shared flag once nobody drives it
   assign flag_pin = flag_oe ? flag_out : (resetn ? 1'b1 : strap_val.mode_c);
   assign ack_pin  = ack_oe ? ack_out : 1'b0;
   always @(negedge mclk)
   begin
      word_done <= 1'b0;
      dma_write <= 1'b0;
      dma_addr  <= ~dma_addr;
      gap       <= ~gap;
      if (!resetn)
      begin
         sent      <= 6'h00;
         step      <= 2'h0;
         gap       <= 1'b0;
         dma_addr  <= 14'h0000;
         dma_to_pm <= 1'b0;
      end
      else if (boot_start && sent < word_limit && !(slow && gap))
      begin
         word_done <= 1'b1;
         sent      <= sent + 6'h01;
      end
      else if (step < host_steps)
      begin
         // data write to 0, program write to 1, then program write to 0
         dma_write <= 1'b1;
         dma_addr  <= (step == 2'h1) ? 14'h0001 : 14'h0000;
         dma_to_pm <= (step != 2'h0);
         step      <= step + 2'h1;
      end
   end
endmodule : rbm_board_model

// ---- verif/rbm_reset_boot_bench.sv ----
// self-checking bench for the reset and boot-mode controller
// assumes the board model beside it and the shared constants header
`timescale 1ns/1ps
`include "rbm_defs.svh"
module rbm_reset_boot_bench
   import rbm_pkg::*;
;
   logic        mclk, resetn, bus_request, flag_two_dir_out, flag_two_value, host_ack_req;
   logic        prog_ext_exec_req, data_access, data_external, wait_state_mode, slow, run_seen;
   logic        core_reset, stacks_empty, irq_mask_all, fetch_enable, fetch_external, boot_start;
   logic        host_mode, flag_out, flag_oe, flag_two_read, ack_out, ack_oe, ovl_addr_a13, ovl_valid;
   logic        ext_exec_allowed, data_ready, word_done, dma_write, dma_to_pm, flag_pin, ack_pin;
   logic [6:0]  mode_status_reg;
   logic [13:0] fetch_addr, dma_addr, prog_addr;
   logic [12:0] ovl_addr_low;
   logic [4:0]  prog_width;
   logic [2:0]  data_wait_states;
   logic [1:0]  prog_overlay_select, host_steps;
   logic [5:0]  word_limit;
   logic [15:0] rnd, lat;
   rbm_straps_t strap_val, straps;
   logic [15:0] q_boot[$], q_lat[$];
   int          n_mismatch, n_tests, cycles;

   rbm_reset_boot #(.BOOT_WORDS(32)) u_rbm_reset_boot
   (
      .mclk(mclk), .resetn(resetn), .straps(straps), .shared_flag_two_in(flag_pin),
      .flag_two_dir_out(flag_two_dir_out), .flag_two_value(flag_two_value), .bus_request(bus_request),
      .byte_mem_dma_word_done(word_done), .host_port_dma_write(dma_write), .host_port_dma_addr(dma_addr),
      .host_port_dma_to_pm(dma_to_pm), .host_ack_req(host_ack_req), .prog_overlay_select(prog_overlay_select),
      .prog_addr(prog_addr), .prog_ext_exec_req(prog_ext_exec_req), .data_access(data_access),
      .data_external(data_external), .data_wait_states(data_wait_states), .wait_state_mode(wait_state_mode),
      .core_reset(core_reset), .stacks_empty(stacks_empty), .irq_mask_all(irq_mask_all),
      .mode_status_reg(mode_status_reg), .fetch_enable(fetch_enable), .fetch_addr(fetch_addr),
      .fetch_external(fetch_external), .byte_mem_dma_boot_start(boot_start), .host_mode(host_mode),
      .shared_flag_two_out(flag_out), .shared_flag_two_oe(flag_oe), .flag_two_read(flag_two_read),
      .host_access_ack_n_out(ack_out), .host_access_ack_n_oe(ack_oe), .ovl_addr_a13(ovl_addr_a13),
      .ovl_addr_low(ovl_addr_low), .ovl_valid(ovl_valid), .ext_exec_allowed(ext_exec_allowed),
      .prog_width(prog_width), .data_ready(data_ready)
   );

   rbm_board_model u_rbm_board_model
   (
      .mclk(mclk), .resetn(resetn), .strap_val(strap_val), .word_limit(word_limit), .slow(slow),
      .host_steps(host_steps), .boot_start(boot_start), .flag_out(flag_out), .flag_oe(flag_oe),
      .ack_out(ack_out), .ack_oe(ack_oe), .straps(straps), .word_done(word_done), .dma_write(dma_write),
      .dma_addr(dma_addr), .dma_to_pm(dma_to_pm), .flag_pin(flag_pin), .ack_pin(ack_pin)
   );

   always #2.5 mclk = ~mclk;

   function automatic logic [15:0] lfsr(input logic [15:0] v);
      return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
   endfunction : lfsr

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
      end
   endtask : check

   task automatic results;
      if (n_mismatch == 0 && n_tests > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : results

   task automatic boot(input rbm_straps_t s, input logic br, input logic sl);
      logic byte_b;
      logic host_b;
      logic hm;
      int   w;
      byte_b      = !s.mode_b && !s.mode_a;
      host_b      = s.mode_c && !s.mode_b && s.mode_a;
      hm          = s.mode_c;
      resetn      = 1'b0;
      strap_val   = s;
      bus_request = br;
      slow        = sl;
      word_limit  = 6'h00;
      host_steps  = 2'h0;
      repeat (3) @(negedge mclk);
      check({core_reset, stacks_empty, irq_mask_all, fetch_enable, 5'h00, mode_status_reg}, 16'hE000);
      q_boot.push_back({hm, !s.mode_c && s.mode_b && !s.mode_a, `RBM_START_ADDR});
      resetn = 1'b1;
      repeat (4) @(negedge mclk);
      bus_request = 1'b0;
      check({15'h0000, fetch_enable}, {15'h0000, br || !(byte_b || host_b)});
      if (!br && byte_b)
      begin
         word_limit = 6'h1F;
         repeat (80) @(negedge mclk);
         check({15'h0000, fetch_enable}, 16'h0000);
         word_limit = `RBM_BOOT_WORDS;
      end
      else if (!br && host_b)
      begin
         host_steps = 2'h2;
         repeat (8) @(negedge mclk);
         check({15'h0000, fetch_enable}, 16'h0000);
         host_steps = 2'h3;
      end
      w = 0;
      while (fetch_enable !== 1'b1 && w < 200)
      begin
         @(negedge mclk);
         w++;
      end
      check({15'h0000, fetch_enable}, 16'h0001);
      for (int i = 0; i < 3; i++)
      begin
         rnd                 = lfsr(rnd);
         prog_overlay_select = 2'(i);
         prog_addr           = {1'b1, rnd[12:0]};
         flag_two_dir_out    = rnd[13];
         flag_two_value      = rnd[14];
         host_ack_req        = rnd[15];
         prog_ext_exec_req   = 1'b1;
         @(negedge mclk);
         if (i == 0)
            check({15'h0000, ovl_valid}, 16'h0000);
         else
            check({ovl_valid, hm ? 1'b0 : ovl_addr_a13, 1'b0, ovl_addr_low},
                  {1'b1, !hm && i == 2, 1'b0, hm ? {12'h000, prog_addr[0]} : prog_addr[12:0]});
         check({flag_oe, flag_two_read, prog_width, ext_exec_allowed, ack_pin | !hm, ack_oe | !hm | s.mode_d,
                host_mode, 5'h00},
               {flag_two_dir_out, flag_two_dir_out ? flag_two_value : 1'b1,
                hm ? 5'(`RBM_HOST_BUS_WIDTH) : 5'(`RBM_PM_WIDTH), !hm, ~host_ack_req | !hm, 1'b1,
                hm, 5'h00});
      end
   endtask : boot

   task automatic access(input logic ext, input logic [2:0] n, input logic md);
      int w;
      data_external    = ext;
      data_wait_states = n;
      wait_state_mode  = md;
      data_access      = 1'b1;
      q_lat.push_back((!ext || n == 3'h0) ? 16'h0001 : md ? 16'(2 * n + 2) : 16'(n + 1));
      @(negedge mclk);
      data_access = 1'b0;
      w           = 0;
      while (data_ready !== 1'b1 && w < 40)
      begin
         @(negedge mclk);
         w++;
      end
      check({15'h0000, data_ready}, 16'h0001);
      @(negedge mclk);
   endtask : access

   // boot outcome and access latency watcher
   always @(negedge mclk)
   begin
      if (fetch_enable === 1'b1 && !run_seen && q_boot.size() > 0)
         check({host_mode, fetch_external, fetch_addr}, q_boot.pop_front());
      run_seen = (fetch_enable === 1'b1);
      if (data_ready === 1'b1 && q_lat.size() > 0)
         check(lat, q_lat.pop_front());
   end

   always @(posedge mclk)
   begin
      lat <= (data_access === 1'b1) ? 16'h0001 : lat + 16'h0001;
      cycles++;
      if (cycles == 20000)
      begin
         n_mismatch++;
         results();
      end
   end

   initial
   begin
      logic [5:0] tbl [8];
      tbl = '{6'h00, 6'h08, 6'h11, 6'h14, 6'h30, 6'h34, 6'h02, 6'h31};
      mclk = 1'b0; resetn = 1'b0; bus_request = 1'b0; flag_two_dir_out = 1'b0; flag_two_value = 1'b0;
      host_ack_req = 1'b0; prog_ext_exec_req = 1'b0; data_access = 1'b0; data_external = 1'b0;
      wait_state_mode = 1'b0; slow = 1'b0; run_seen = 1'b0; data_wait_states = 3'h0;
      prog_overlay_select = 2'h0; prog_addr = 14'h0000; host_steps = 2'h0; word_limit = 6'h00;
      rnd = 16'h8EFD; lat = 16'h0000; strap_val = 4'h0; n_mismatch = 0; n_tests = 0; cycles = 0;
      // short stand-in for the long power-up hold of the board reset
      repeat (20) @(negedge mclk);
      for (int i = 0; i < 8; i++)
         boot(tbl[i][5:2], tbl[i][1], tbl[i][0]);
      access(1'b0, 3'h5, 1'b1);
      access(1'b1, 3'h7, 1'b0);
      access(1'b1, 3'h7, 1'b1);
      access(1'b1, 3'h0, 1'b0);
      for (int i = 0; i < 8; i++)
      begin
         rnd = lfsr(rnd);
         access(rnd[3], rnd[0] ? rnd[6:4] | 3'h1 : rnd[6:4], rnd[0]);
      end
      results();
   end
endmodule : rbm_reset_boot_bench
